//--- rtl/sms_pkg.sv
/*
 * Constants for the supply monitor, status and shutdown block.
 * Assumes a 125 MHz clock and 8-bit registers behind the serial port.
 */
package sms_pkg;
	// ********************************
	// Clock
	// ********************************
	localparam int CLK_PERIOD_NS = 8;
	// ********************************
	// Register offsets
	// ********************************
	localparam logic [6:0] BAT_HIGH_ADDR   = 7'h15;
	localparam logic [6:0] BAT_LOW_ADDR    = 7'h16;
	localparam logic [6:0] SENSE_HIGH_ADDR = 7'h17;
	localparam logic [6:0] SENSE_LOW_ADDR  = 7'h18;
	localparam logic [6:0] VSEL_ADDR       = 7'h1a;
	localparam logic [6:0] STATUS_ADDR     = 7'h1b;
	// ********************************
	// Fields and values
	// ********************************
	localparam int          FLAG_BIT       = 2;
	localparam int          OVS_BIT        = 5;
	localparam int          UVS_BIT        = 4;
	localparam int          WIN_BIT        = 3;
	localparam int          MAIN_BIT       = 0;
	localparam logic [1:0]  EXT_OK         = 2'h0;
	localparam logic [1:0]  EXT_UNDER      = 2'h1;
	localparam logic [1:0]  EXT_OVER       = 2'h2;
	localparam logic [1:0]  EXT_OFF        = 2'h3;
	localparam logic [3:0]  VSEL_DEFAULT   = 4'h5;
	localparam logic [4:0]  RSRC_OVERLOAD  = 5'h12;
	localparam logic [4:0]  RSRC_NONE      = 5'h00;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	typedef enum logic [1:0] {SMS_RUN, SMS_SD_TIMER, SMS_OVERLOAD, SMS_RESET} sms_state_t;
endpackage : sms_pkg

//--- rtl/sms_supply_monitor.sv
/*
 * Supply monitor: conversion results, supply status, converter window
 * status and overvoltage shutdown sequence.
 * Assumes all inputs except arst_n synchronous to clk; register port driven by the
 * serial frame decoder with one-cycle read and write strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module sms_supply_monitor
	import sms_pkg::*;
#(
	parameter int OV_DET_NS  = 20000,
	parameter int OV_SD_NS   = 100000,
	parameter int WIN_TO_NS  = 20000
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [6:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        normal_mode,
	input  wire logic        battery_conv_valid,
	input  wire logic [9:0]  battery_conversion_result,
	input  wire logic        sense_conv_valid,
	input  wire logic [9:0]  sense_conversion_result,
	input  wire logic        monitor_source_select,
	input  wire logic [7:0]  over_threshold_setting,
	input  wire logic [7:0]  under_threshold_setting,
	input  wire logic        converter_in_window,
	input  wire logic        pass_through,
	input  wire logic        converter_window_irq_enable,
	input  wire logic        ext_under,
	input  wire logic        ext_over,
	input  wire logic        ext_disabled,
	input  wire logic        main_regulator_low,
	input  wire logic        supply_above_ov_det,
	input  wire logic        supply_below_ov_rel,
	input  wire logic        reset_pin_n,
	output logic             converter_window_irq,
	output logic             overvoltage_shutdown_irq,
	output logic             overload_mode,
	output logic             reset_mode,
	output logic             system_reset,
	output logic      [4:0]  reset_source_code,
	output logic             converter_enable,
	output logic      [3:0]  converter_voltage_select
);
	// ********************************
	// Timing
	// ********************************
	localparam int OV_DET_CYC = (OV_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OV_SD_CYC  = (OV_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIN_TO_CYC = (WIN_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CW = 24;

	// ********************************
	// Reset release
	// ********************************
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) rst_sync_reg <= 2'h0;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ********************************
	// Conversion results
	// ********************************
	logic [9:0] bat_res_reg;
	logic [9:0] sense_res_reg;
	logic       battery_high_read_flag_reg;
	logic       sense_high_read_flag_reg;
	logic       rd_bat_high;
	logic       rd_sense_high;
	assign rd_bat_high   = reg_rd && (reg_addr == BAT_HIGH_ADDR);
	assign rd_sense_high = reg_rd && (reg_addr == SENSE_HIGH_ADDR);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bat_res_reg   <= 10'h000;
			sense_res_reg <= 10'h000;
		end else if (normal_mode) begin
			if (battery_conv_valid) bat_res_reg <= battery_conversion_result;
			if (sense_conv_valid) sense_res_reg <= sense_conversion_result;
		end
	end

	// New result clears the flag; reading the high byte sets it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			battery_high_read_flag_reg <= 1'b0;
			sense_high_read_flag_reg   <= 1'b0;
		end else begin
			if (normal_mode && battery_conv_valid) battery_high_read_flag_reg <= 1'b0;
			else if (rd_bat_high) battery_high_read_flag_reg <= 1'b1;
			if (normal_mode && sense_conv_valid) sense_high_read_flag_reg <= 1'b0;
			else if (rd_sense_high) sense_high_read_flag_reg <= 1'b1;
		end
	end

	// ********************************
	// Supply status
	// ********************************
	logic [7:0] sel_high;
	logic       over_threshold_status;
	logic       under_threshold_status;
	logic [1:0] external_supply_status;
	assign sel_high = monitor_source_select ? sense_res_reg[9:2] : bat_res_reg[9:2];
	assign over_threshold_status  = normal_mode && (sel_high > over_threshold_setting);
	assign under_threshold_status = normal_mode && (sel_high < under_threshold_setting);
	assign external_supply_status = ext_disabled ? EXT_OFF : ext_over ? EXT_OVER :
		ext_under ? EXT_UNDER : EXT_OK;

	// ********************************
	// Converter window
	// ********************************
	logic          converter_window_status_reg;
	logic [CW-1:0] win_cnt_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_window_status_reg <= 1'b0;
			win_cnt_reg                 <= '0;
			converter_window_irq        <= 1'b0;
		end else begin
			converter_window_irq <= 1'b0;
			if (converter_in_window) begin
				converter_window_status_reg <= 1'b0;
				win_cnt_reg                 <= '0;
			end else if (pass_through) begin
				converter_window_status_reg <= 1'b1;
				win_cnt_reg                 <= '0;
			end else if (win_cnt_reg >= CW'(WIN_TO_CYC)) begin
				converter_window_status_reg <= 1'b1;
				converter_window_irq <= !converter_window_status_reg &&
					converter_window_irq_enable;
			end else begin
				win_cnt_reg <= win_cnt_reg + 1'b1;
			end
		end
	end

	AST_WIN_IRQ_GATED: assert property (@(posedge clk) disable iff (!rst_n)
		converter_window_irq |-> $past(converter_window_irq_enable) && converter_window_status_reg
		&& !$past(pass_through)) else $error("window irq without enable");
	AST_WIN_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		converter_in_window |=> !converter_window_status_reg)
		else $error("window status not cleared");
	AST_WIN_NO_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(converter_window_status_reg) && !$past(pass_through)
		|-> $past(win_cnt_reg) >= CW'(WIN_TO_CYC)) else $error("window set early");

	// ********************************
	// Overvoltage shutdown
	// ********************************
	sms_state_t    state_reg;
	logic [CW-1:0] ov_cnt_reg;
	logic [CW-1:0] sd_cnt_reg;
	logic          released_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ov_cnt_reg <= '0;
		else if (!supply_above_ov_det || state_reg != SMS_RUN) ov_cnt_reg <= '0;
		else if (ov_cnt_reg <= CW'(OV_DET_CYC)) ov_cnt_reg <= ov_cnt_reg + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg                <= SMS_RUN;
			sd_cnt_reg               <= '0;
			released_reg             <= 1'b0;
			overvoltage_shutdown_irq <= 1'b0;
			overload_mode            <= 1'b0;
			reset_mode               <= 1'b0;
			system_reset             <= 1'b0;
			reset_source_code        <= RSRC_NONE;
		end else begin
			overvoltage_shutdown_irq <= 1'b0;
			system_reset             <= 1'b0;
			reset_mode               <= 1'b0;
			case (state_reg)
				SMS_RUN: begin
					if (ov_cnt_reg > CW'(OV_DET_CYC)) begin
						overvoltage_shutdown_irq <= 1'b1;
						sd_cnt_reg               <= '0;
						released_reg             <= 1'b0;
						state_reg                <= SMS_SD_TIMER;
					end
				end
				SMS_SD_TIMER: begin
					if (supply_below_ov_rel) released_reg <= 1'b1;
					if (sd_cnt_reg >= CW'(OV_SD_CYC - 1)) begin
						if (released_reg || supply_below_ov_rel) begin
							system_reset      <= 1'b1;
							reset_mode        <= 1'b1;
							reset_source_code <= RSRC_OVERLOAD;
							state_reg         <= SMS_RESET;
						end else begin
							overload_mode <= 1'b1;
							state_reg     <= SMS_OVERLOAD;
						end
					end else begin
						sd_cnt_reg <= sd_cnt_reg + 1'b1;
					end
				end
				SMS_OVERLOAD: begin
					if (supply_below_ov_rel) begin
						overload_mode     <= 1'b0;
						system_reset      <= 1'b1;
						reset_mode        <= 1'b1;
						reset_source_code <= RSRC_OVERLOAD;
						state_reg         <= SMS_RESET;
					end
				end
				SMS_RESET: state_reg <= SMS_RUN;
				default: state_reg <= SMS_RUN;
			endcase
		end
	end

	AST_IRQ_AFTER_DET: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(overvoltage_shutdown_irq) |-> $past(supply_above_ov_det, 2)
		&& $past(ov_cnt_reg) > CW'(OV_DET_CYC)) else $error("ov irq too early");
	AST_IRQ_STARTS_TIMER: assert property (@(posedge clk) disable iff (!rst_n)
		overvoltage_shutdown_irq |-> state_reg == SMS_SD_TIMER && sd_cnt_reg == '0)
		else $error("timer not started");
	AST_RESET_CODE: assert property (@(posedge clk) disable iff (!rst_n)
		system_reset |-> reset_source_code == RSRC_OVERLOAD && reset_mode)
		else $error("bad reset source");
	AST_OVERLOAD_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(overload_mode) |-> system_reset ##1 state_reg == SMS_RUN)
		else $error("overload exit without reset");
	AST_RELEASE_RESET: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == SMS_SD_TIMER && supply_below_ov_rel |=> !overload_mode)
		else $error("overload after release");

	// ********************************
	// Converter control
	// ********************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_enable         <= 1'b1;
			converter_voltage_select <= VSEL_DEFAULT;
		end else if (!reset_pin_n) begin
			converter_enable         <= 1'b1;
			converter_voltage_select <= VSEL_DEFAULT;
		end else if (reg_wr && reg_addr == VSEL_ADDR) begin
			converter_voltage_select <= reg_wdata[3:0];
		end
	end

	AST_PIN_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n)
		!reset_pin_n |=> converter_voltage_select == VSEL_DEFAULT && converter_enable)
		else $error("default not restored");

	// ********************************
	// Register read
	// ********************************
	logic [7:0] status_byte;
	always_comb begin
		status_byte                = BYTE_ZERO;
		status_byte[OVS_BIT]       = over_threshold_status;
		status_byte[UVS_BIT]       = under_threshold_status;
		status_byte[WIN_BIT]       = converter_window_status_reg;
		status_byte[2:1]           = external_supply_status;
		status_byte[MAIN_BIT]      = main_regulator_low;
	end

	// Writes outside the voltage select register change nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) reg_rdata <= BYTE_ZERO;
		else if (reg_rd) begin
			case (reg_addr)
				BAT_HIGH_ADDR:   reg_rdata <= bat_res_reg[9:2];
				BAT_LOW_ADDR:    reg_rdata <= {5'h00, battery_high_read_flag_reg,
					bat_res_reg[1:0]};
				SENSE_HIGH_ADDR: reg_rdata <= sense_res_reg[9:2];
				SENSE_LOW_ADDR:  reg_rdata <= {5'h00, sense_high_read_flag_reg,
					sense_res_reg[1:0]};
				VSEL_ADDR:       reg_rdata <= {4'h0, converter_voltage_select};
				STATUS_ADDR:     reg_rdata <= status_byte;
				default:         reg_rdata <= BYTE_ZERO;
			endcase
		end
	end

	AST_FLAG_ON_READ: assert property (@(posedge clk) disable iff (!rst_n)
		rd_bat_high && !(normal_mode && battery_conv_valid) |=> battery_high_read_flag_reg)
		else $error("high read flag not set");
	AST_THRESH_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!normal_mode |-> !over_threshold_status && !under_threshold_status)
		else $error("threshold flag outside normal");
endmodule : sms_supply_monitor
`default_nettype wire

//--- tb/tb.sv
/*
 * Testbench for sms_supply_monitor: register reads, status byte,
 * converter window, overvoltage shutdown and reset pin.
 * Assumes the design with short detection, shutdown and time-out figures.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
	import sms_pkg::*;
;
	// ********************************
	// Signals
	// ********************************
	logic clk = 0, arst_n = 0, reg_rd = 0, reg_wr = 0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic normal_mode = 1, bat_v = 0, sen_v = 0, sel = 0;
	logic [9:0] bat_r = 10'h2b5, sen_r = 10'h016;
	logic [7:0] ovt = 8'h80, uvt = 8'h10;
	logic in_win = 1, pt = 0, wie = 0, e_u = 0, e_o = 0, e_d = 0, m_low = 0;
	logic det = 0, rel = 0, rpin_n = 1;
	logic wirq, ovirq, ovl, rmode, srst, cen;
	logic [4:0] rsrc;
	logic [3:0] vsel;
	int n_fail = 0, n_checks = 0, n_wirq = 0, n_ovirq = 0, n_srst = 0, n_rmode = 0;

	sms_supply_monitor #(.OV_DET_NS(80), .OV_SD_NS(160), .WIN_TO_NS(80)) i_dut (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.normal_mode(normal_mode), .battery_conv_valid(bat_v),
		.battery_conversion_result(bat_r), .sense_conv_valid(sen_v),
		.sense_conversion_result(sen_r), .monitor_source_select(sel),
		.over_threshold_setting(ovt), .under_threshold_setting(uvt),
		.converter_in_window(in_win), .pass_through(pt),
		.converter_window_irq_enable(wie), .ext_under(e_u), .ext_over(e_o),
		.ext_disabled(e_d), .main_regulator_low(m_low), .supply_above_ov_det(det),
		.supply_below_ov_rel(rel), .reset_pin_n(rpin_n), .converter_window_irq(wirq),
		.overvoltage_shutdown_irq(ovirq), .overload_mode(ovl), .reset_mode(rmode),
		.system_reset(srst), .reset_source_code(rsrc), .converter_enable(cen),
		.converter_voltage_select(vsel));

	initial begin
		forever #4 clk = ~clk;
	end

	// ********************************
	// Pulse counters
	// ********************************
	always @(posedge clk) begin
		if (wirq === 1'b1) n_wirq++;
		if (ovirq === 1'b1) n_ovirq++;
		if (srst === 1'b1) n_srst++;
		if (rmode === 1'b1) n_rmode++;
	end

	// ********************************
	// Helpers
	// ********************************
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		chk("rdata", reg_rdata, exp);
		cyc(1);
	endtask : rd

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
		cyc(1);
	endtask : wr

	task automatic end_sim;
		if (n_fail == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_results;
		bat_v = 1;
		sen_v = 1;
		cyc(1);
		bat_v = 0;
		sen_v = 0;
		rd(BAT_LOW_ADDR, 8'h01);
		rd(BAT_HIGH_ADDR, 8'had);
		rd(BAT_LOW_ADDR, 8'h05);
		rd(SENSE_LOW_ADDR, 8'h02);
		rd(SENSE_HIGH_ADDR, 8'h05);
		wr(SENSE_LOW_ADDR, 8'hff);
		rd(SENSE_LOW_ADDR, 8'h06);
		sen_v = 1;
		cyc(1);
		sen_v = 0;
		rd(SENSE_LOW_ADDR, 8'h02);
	endtask : t_results

	task automatic t_status;
		rd(STATUS_ADDR, 8'h20);
		sel = 1;
		wr(STATUS_ADDR, 8'hff);
		rd(STATUS_ADDR, 8'h10);
		normal_mode = 0;
		rd(STATUS_ADDR, 8'h00);
		for (int i = 0; i < 4; i++) begin
			e_u = (i == 1);
			e_o = (i == 2);
			e_d = (i == 3);
			rd(STATUS_ADDR, 8'(i * 2));
		end
		{e_u, e_o, e_d} = 3'b000;
		m_low = 1;
		rd(STATUS_ADDR, 8'h01);
		m_low = 0;
	endtask : t_status

	task automatic t_window;
		wie = 1;
		in_win = 0;
		cyc(7);
		rd(STATUS_ADDR, 8'h00);
		cyc(6);
		rd(STATUS_ADDR, 8'h08);
		chk("window irq", 8'(n_wirq), 8'h01);
		in_win = 1;
		cyc(2);
		rd(STATUS_ADDR, 8'h00);
		wie = 0;
		in_win = 0;
		cyc(15);
		rd(STATUS_ADDR, 8'h08);
		chk("window irq", 8'(n_wirq), 8'h01);
		in_win = 1;
		wie = 1;
		cyc(2);
		pt = 1;
		in_win = 0;
		cyc(2);
		rd(STATUS_ADDR, 8'h08);
		cyc(15);
		chk("window irq", 8'(n_wirq), 8'h01);
		in_win = 1;
		pt = 0;
		cyc(2);
		rd(STATUS_ADDR, 8'h00);
	endtask : t_window

	task automatic t_shutdown;
		det = 1;
		cyc(10);
		det = 0;
		cyc(3);
		chk("ov irq", 8'(n_ovirq), 8'h00);
		det = 1;
		cyc(14);
		det = 0;
		chk("ov irq", 8'(n_ovirq), 8'h01);
		cyc(24);
		chk("overload", {7'h0, ovl}, 8'h01);
		chk("reset count", 8'(n_srst), 8'h00);
		rel = 1;
		cyc(2);
		rel = 0;
		chk("overload", {7'h0, ovl}, 8'h00);
		chk("reset count", 8'(n_srst), 8'h01);
		chk("reset source", {3'h0, rsrc}, 8'h12);
		cyc(2);
		det = 1;
		cyc(14);
		det = 0;
		rel = 1;
		cyc(3);
		rel = 0;
		cyc(24);
		chk("ov irq", 8'(n_ovirq), 8'h02);
		chk("overload", {7'h0, ovl}, 8'h00);
		chk("reset count", 8'(n_srst), 8'h02);
		chk("reset mode count", 8'(n_rmode), 8'h02);
	endtask : t_shutdown

	task automatic t_reset_pin;
		wr(VSEL_ADDR, 8'h0c);
		rd(VSEL_ADDR, 8'h0c);
		rpin_n = 0;
		cyc(1);
		rpin_n = 1;
		cyc(2);
		chk("voltage select", {4'h0, vsel}, {4'h0, VSEL_DEFAULT});
		chk("converter enable", {7'h0, cen}, 8'h01);
		rd(VSEL_ADDR, 8'h05);
	endtask : t_reset_pin

	// ********************************
	// Main sequence and watchdog
	// ********************************
	initial begin
		cyc(8);
		arst_n = 1;
		cyc(3);
		chk("voltage select", {4'h0, vsel}, 8'h05);
		chk("converter enable", {7'h0, cen}, 8'h01);
		chk("reset source", {3'h0, rsrc}, 8'h00);
		t_results();
		t_status();
		t_window();
		t_shutdown();
		t_reset_pin();
		end_sim();
	end

	initial begin
		#40000;
		n_fail++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
